// File: logic/rail_control_register_slice.sv
`timescale 1ns/1ns
`include "rail_ctrl_map.svh"

// Operation
// - The sleep code in bits 7:4 drives the third regulator's target while sleep mode is active.
// - The normal code in bits 3:0 drives the third regulator's target during normal operation.
// - Converter control bit 3 picks automatic (0) or forced PWM (1) for the first converter.
// - Converter control bit 4 picks automatic (0) or forced PWM (1) for the second converter.
// - Bit 5 set to 1 forces PWM on the third converter and the host must not write 0 there.
// - Bits 2..0 at 0 force the third, second and first converters off regardless of control pins.
// - Each output's delay starts when all its rails are in regulation and power good follows after it.
// - The second output's 3-bit delay in bits 7:5 maps to 0, 5, 10, 15, 20 and 50 ms.
// - The fourth output's 3-bit delay in bits 4:2 uses the same mapping as the second output.
// - The first output's 2-bit delay in bits 1:0 maps to 0, 5, 10 and 15 ms.
// - A bus-driven output ignores its delay, unless the second output feeds termination enable.
// - Switch force-off bits 7..4 at 0 turn the switch or termination regulator off regardless of pins.
module rail_control_register_slice #(
    parameter int CYC_PER_MS = `CYC_PER_MS,
    parameter int CNT_W = 21
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire rail_ctrl_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic sleep_active,
    input wire rail_ctrl_pkg::rail_en_t pin_enable,
    input wire logic [2:0] rails_in_regulation,
    input wire logic [2:0] out_bus_controlled,
    input wire logic out2_feeds_termination,
    output rail_ctrl_pkg::rail_en_t rail_enable,
    output logic [2:0] conv_pwm,
    output logic [3:0] ldo_three_target,
    output logic [2:0] power_good
);

    // Register file
    logic [7:0] ldo3_codes_r;
    logic [7:0] ldo3_codes_nxt;
    logic [7:0] conv_ctrl_r;
    logic [7:0] conv_ctrl_nxt;
    logic [7:0] good_delay_r;
    logic [7:0] good_delay_nxt;
    logic [7:0] sw_off_r;
    logic [7:0] sw_off_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Register writes and the registered read path
    always_comb
    begin
        ldo3_codes_nxt = ldo3_codes_r;
        conv_ctrl_nxt = conv_ctrl_r;
        good_delay_nxt = good_delay_r;
        sw_off_nxt = sw_off_r;
        rdata_nxt = rdata_r;
        if (reg_req.write)
        begin
            case (reg_req.addr)
                `OFS_LDO3_CODES:
                begin
                    ldo3_codes_nxt = reg_req.wdata;
                end
                `OFS_CONV_CTRL:
                begin
                    // Top two bits are read-only zero
                    conv_ctrl_nxt = {2'h0, reg_req.wdata[`CONV3_PWM_BIT:`CONV1_OFF_BIT]};
                end
                `OFS_GOOD_DELAY:
                begin
                    good_delay_nxt = reg_req.wdata;
                end
                `OFS_SW_FORCE_OFF:
                begin
                    // Reserved low bits are stored as written; host keeps them zero
                    sw_off_nxt = reg_req.wdata;
                end
                default:
                begin
                    sw_off_nxt = sw_off_r;
                end
            endcase
        end
        if (reg_req.read)
        begin
            case (reg_req.addr)
                `OFS_LDO3_CODES:
                begin
                    rdata_nxt = ldo3_codes_r;
                end
                `OFS_CONV_CTRL:
                begin
                    rdata_nxt = conv_ctrl_r;
                end
                `OFS_GOOD_DELAY:
                begin
                    rdata_nxt = good_delay_r;
                end
                `OFS_SW_FORCE_OFF:
                begin
                    rdata_nxt = sw_off_r;
                end
                default:
                begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    // Synchronous reset takes priority over the clock enable
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ldo3_codes_r <= `RST_LDO3_CODES;
            conv_ctrl_r <= `RST_CONV_CTRL;
            good_delay_r <= `RST_GOOD_DELAY;
            sw_off_r <= `RST_SW_FORCE_OFF;
            rdata_r <= 8'h00;
        end
        else if (ce)
        begin
            ldo3_codes_r <= ldo3_codes_nxt;
            conv_ctrl_r <= conv_ctrl_nxt;
            good_delay_r <= good_delay_nxt;
            sw_off_r <= sw_off_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Read data stands until the next read strobe
    assign reg_rdata = rdata_r;

    // Rail enables, mode selects and regulator target
    rail_ctrl_pkg::rail_en_t en_r;
    rail_ctrl_pkg::rail_en_t en_nxt;
    logic [2:0] pwm_r;
    logic [2:0] pwm_nxt;
    logic [3:0] target_r;
    logic [3:0] target_nxt;
    logic term_request;

    // Termination may also be requested by the second output's power good
    assign term_request = pin_enable.term | (out2_feeds_termination & power_good[1]);

    always_comb
    begin
        en_nxt.conv1 = pin_enable.conv1 & conv_ctrl_r[`CONV1_OFF_BIT];
        en_nxt.conv2 = pin_enable.conv2 & conv_ctrl_r[`CONV2_OFF_BIT];
        en_nxt.conv3 = pin_enable.conv3 & conv_ctrl_r[`CONV3_OFF_BIT];
        en_nxt.term = term_request & sw_off_r[`TERM_OFF_BIT];
        en_nxt.swa1 = pin_enable.swa1 & sw_off_r[`SWA1_OFF_BIT];
        en_nxt.swb1 = pin_enable.swb1 & sw_off_r[`SWB1_OFF_BIT];
        en_nxt.swb2_ldo1 = pin_enable.swb2_ldo1 & sw_off_r[`SWB2_OFF_BIT];
        pwm_nxt[0] = conv_ctrl_r[`CONV1_PWM_BIT];
        pwm_nxt[1] = conv_ctrl_r[`CONV2_PWM_BIT];
        pwm_nxt[2] = conv_ctrl_r[`CONV3_PWM_BIT];
        if (sleep_active)
        begin
            target_nxt = ldo3_codes_r[`LDO3_SLEEP_MSB:`LDO3_SLEEP_LSB];
        end
        else
        begin
            target_nxt = ldo3_codes_r[`LDO3_NORMAL_MSB:`LDO3_NORMAL_LSB];
        end
    end

    // Registered so that the enables never glitch
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            en_r <= '0;
            pwm_r <= 3'h0;
            target_r <= 4'h0;
        end
        else if (ce)
        begin
            en_r <= en_nxt;
            pwm_r <= pwm_nxt;
            target_r <= target_nxt;
        end
    end

    assign rail_enable = en_r;
    assign conv_pwm = pwm_r;
    assign ldo_three_target = target_r;

    // Delay code to milliseconds; the 2-bit field is zero-extended
    function automatic logic [5:0] code_to_ms(input logic [2:0] code);
        logic [5:0] ms;
        ms = 6'(`DLY_MS_0);
        case (code)
            3'h0: ms = 6'(`DLY_MS_0);
            3'h1: ms = 6'(`DLY_MS_5);
            3'h2: ms = 6'(`DLY_MS_10);
            3'h3: ms = 6'(`DLY_MS_15);
            3'h4: ms = 6'(`DLY_MS_20);
            3'h5: ms = 6'(`DLY_MS_50);
            3'h7: ms = 6'(`DLY_MS_50);
            // Code 6 is not defined; it takes the longest delay
            default: ms = 6'(`DLY_MS_50);
        endcase
        return ms;
    endfunction

    // Each output's field widened to the common code width
    logic [2:0] dly_code [3];
    assign dly_code[0] = {1'b0, good_delay_r[`OUT1_DLY_MSB:`OUT1_DLY_LSB]};
    assign dly_code[1] = good_delay_r[`OUT2_DLY_MSB:`OUT2_DLY_LSB];
    assign dly_code[2] = good_delay_r[`OUT4_DLY_MSB:`OUT4_DLY_LSB];

    // Power-good delay timers: index 0 first output, 1 second, 2 fourth
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_good
            rail_ctrl_pkg::good_timer_t st_r;
            rail_ctrl_pkg::good_timer_t st_nxt;
            logic [CNT_W-1:0] cnt_r;
            logic [CNT_W-1:0] cnt_nxt;
            logic [CNT_W-1:0] limit;
            logic active;

            // Delay in clock cycles for the programmed code
            assign limit = CNT_W'(code_to_ms(dly_code[g]) * CYC_PER_MS);
            // Bus-driven outputs leave the timer idle, unless the second output feeds termination
            if (g == 1)
            begin : g_term
                assign active = ~out_bus_controlled[g] | out2_feeds_termination;
            end
            else
            begin : g_plain
                assign active = ~out_bus_controlled[g];
            end

            // Losing regulation, or going bus-driven unless the second output feeds termination, restarts the timer
            always_comb
            begin
                st_nxt = st_r;
                cnt_nxt = cnt_r;
                if (!active || !rails_in_regulation[g])
                begin
                    st_nxt = rail_ctrl_pkg::TMR_IDLE;
                    cnt_nxt = '0;
                end
                else
                begin
                    case (st_r)
                        rail_ctrl_pkg::TMR_IDLE:
                        begin
                            // Delay starts when all assigned rails are in regulation
                            st_nxt = (limit == '0) ? rail_ctrl_pkg::TMR_DONE : rail_ctrl_pkg::TMR_WAIT;
                            cnt_nxt = CNT_W'(1);
                        end
                        rail_ctrl_pkg::TMR_WAIT:
                        begin
                            if (cnt_r >= limit)
                            begin
                                st_nxt = rail_ctrl_pkg::TMR_DONE;
                            end
                            else
                            begin
                                cnt_nxt = cnt_r + CNT_W'(1);
                            end
                        end
                        rail_ctrl_pkg::TMR_DONE:
                        begin
                            st_nxt = rail_ctrl_pkg::TMR_DONE;
                        end
                        default:
                        begin
                            st_nxt = rail_ctrl_pkg::TMR_IDLE;
                            cnt_nxt = '0;
                        end
                    endcase
                end
            end

            // Timer registers; reset clears them whatever the clock enable
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    st_r <= rail_ctrl_pkg::TMR_IDLE;
                    cnt_r <= '0;
                end
                else if (ce)
                begin
                    st_r <= st_nxt;
                    cnt_r <= cnt_nxt;
                end
            end

            assign power_good[g] = (st_r == rail_ctrl_pkg::TMR_DONE);
        end
    endgenerate

endmodule // rail_control_register_slice

// File: logic/rail_ctrl_map.svh
`ifndef RAIL_CTRL_MAP_SVH
`define RAIL_CTRL_MAP_SVH

// Register offsets on the management port
`define OFS_LDO3_CODES 8'h9B
`define OFS_CONV_CTRL 8'h9C
`define OFS_GOOD_DELAY 8'h9D
`define OFS_SW_FORCE_OFF 8'h9F

// Reset values
`define RST_LDO3_CODES 8'h00
`define RST_CONV_CTRL 8'h00
`define RST_GOOD_DELAY 8'h00
`define RST_SW_FORCE_OFF 8'h00

// Field positions: regulator three codes
`define LDO3_SLEEP_MSB 7
`define LDO3_SLEEP_LSB 4
`define LDO3_NORMAL_MSB 3
`define LDO3_NORMAL_LSB 0

// Field positions: converter control
`define CONV_RO_MSB 7
`define CONV_RO_LSB 6
`define CONV1_PWM_BIT 3
`define CONV2_PWM_BIT 4
`define CONV3_PWM_BIT 5
`define CONV1_OFF_BIT 0
`define CONV2_OFF_BIT 1
`define CONV3_OFF_BIT 2

// Field positions: power-good delays
`define OUT2_DLY_MSB 7
`define OUT2_DLY_LSB 5
`define OUT4_DLY_MSB 4
`define OUT4_DLY_LSB 2
`define OUT1_DLY_MSB 1
`define OUT1_DLY_LSB 0

// Field positions: switch and termination force-off
`define TERM_OFF_BIT 4
`define SWA1_OFF_BIT 5
`define SWB1_OFF_BIT 6
`define SWB2_OFF_BIT 7
`define SW_RSVD_MSB 3
`define SW_RSVD_LSB 0

// Timing
`define CLK_HZ 20000000
`define MS_PER_S 1000
`define CYC_PER_MS (`CLK_HZ / `MS_PER_S)
`define DLY_MS_0 0
`define DLY_MS_5 5
`define DLY_MS_10 10
`define DLY_MS_15 15
`define DLY_MS_20 20
`define DLY_MS_50 50

`endif

// File: logic/rail_ctrl_pkg.sv
package rail_ctrl_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic swb2_ldo1;
        logic swb1;
        logic swa1;
        logic term;
        logic conv3;
        logic conv2;
        logic conv1;
    } rail_en_t;

    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_WAIT,
        TMR_DONE
    } good_timer_t;

endpackage

// File: testbench/rail_chk.sv
`timescale 1ns/1ns
module rail_chk #(
    parameter int CYC_PER_MS = 20000,
    parameter int CNT_W = 21
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire rail_ctrl_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic sleep_active,
    input wire rail_ctrl_pkg::rail_en_t pin_enable,
    input wire logic [2:0] rails_in_regulation,
    input wire logic [2:0] out_bus_controlled,
    input wire logic out2_feeds_termination,
    input wire rail_ctrl_pkg::rail_en_t rail_enable,
    input wire logic [2:0] conv_pwm,
    input wire logic [3:0] ldo_three_target,
    input wire logic [2:0] power_good
);
    // Mirror of the regulator-three code register
    logic [7:0] codes_r;
    always_ff @(posedge clk)
    begin
        if (!rstn)
            codes_r <= 8'h00;
        else if (ce && reg_req.write && reg_req.addr == 8'h9B)
            codes_r <= reg_req.wdata;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_pin_gate: assert property (ce |=> ((rail_enable & ~$past(pin_enable)) & 7'h77) == 7'h00)
        else $error("rail enabled without pin request");
    a_term_source: assert property (ce |=> !rail_enable.term ||
        ($past(pin_enable.term) || $past(out2_feeds_termination && power_good[1])))
        else $error("termination enabled without source");
    a_mode_write: assert property (ce && reg_req.write && reg_req.addr == 8'h9C ##1 ce |=>
        conv_pwm == $past(reg_req.wdata[5:3], 2)) else $error("mode select mismatch");
    a_conv_off: assert property (ce && reg_req.write && reg_req.addr == 8'h9C ##1 ce |=>
        (rail_enable[2:0] & ~$past(reg_req.wdata[2:0], 2)) == 3'b000) else $error("converter not off");
    a_switch_off: assert property (ce && reg_req.write && reg_req.addr == 8'h9F ##1 ce |=>
        (rail_enable[6:3] & ~$past(reg_req.wdata[7:4], 2)) == 4'h0) else $error("switch not off");
    a_ldo_target: assert property (ce |=> ldo_three_target ==
        ($past(sleep_active) ? $past(codes_r[7:4]) : $past(codes_r[3:0]))) else $error("target mismatch");
    a_bus_quiet: assert property (ce |=> (power_good & $past(out_bus_controlled) &
        {2'b10 | {1'b0, !$past(out2_feeds_termination)}, 1'b1}) == 3'b000) else $error("bus output timed");
    a_good_needs_reg: assert property (ce |=> (power_good & ~$past(rails_in_regulation)) == 3'b000)
        else $error("good without regulation");
    a_unmapped_zero: assert property (ce && reg_req.read && !(reg_req.addr inside {8'h9B, 8'h9C, 8'h9D, 8'h9F})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_hold_frozen: assert property (!ce |=> $stable(conv_pwm) && $stable(rail_enable) && $stable(power_good))
        else $error("outputs moved while disabled");
    c_sleep: cover property ($rose(sleep_active) ##1 ce);
    c_good: cover property ($rose(power_good[1]));
    c_term: cover property (rail_enable.term && !pin_enable.term);
endmodule // rail_chk

// File: testbench/rail_control_register_slice_tb.sv
`timescale 1ns/1ns
module rail_control_register_slice_tb;
    localparam int CPM = 2;
    logic clk, rstn, ce, sleep_active, out2_feeds_termination;
    rail_ctrl_pkg::reg_req_t reg_req;
    rail_ctrl_pkg::rail_en_t pin_enable, rail_enable;
    logic [7:0] reg_rdata, d;
    logic [2:0] rails_in_regulation, out_bus_controlled, conv_pwm, power_good;
    logic [3:0] ldo_three_target;
    int fails, n_compared, n;
    int ms [8] = '{0, 5, 10, 15, 20, 50, 50, 50};
    logic [7:0] adr [4] = '{8'h9B, 8'h9C, 8'h9D, 8'h9F};
    // Rows: mode byte, force-off byte, pin enables, expected enables, expected pwm
    logic [32:0] rows [4] = '{{8'hFF, 8'hFF, 7'h7F, 7'h7F, 3'h7}, {8'h20, 8'h00, 7'h7F, 7'h00, 3'h4},
        {8'h2D, 8'hA0, 7'h7F, 7'h55, 3'h5}, {8'h37, 8'h50, 7'h2A, 7'h2A, 3'h6}};
    rail_control_register_slice #(.CYC_PER_MS(CPM)) rail_control_register_slice_inst (.clk(clk), .rstn(rstn),
        .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata), .sleep_active(sleep_active), .pin_enable(pin_enable),
        .rails_in_regulation(rails_in_regulation), .out_bus_controlled(out_bus_controlled),
        .out2_feeds_termination(out2_feeds_termination), .rail_enable(rail_enable), .conv_pwm(conv_pwm),
        .ldo_three_target(ldo_three_target), .power_good(power_good));
    rail_host rail_host_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic good_wait(input int g, input int e);
        rails_in_regulation[g] = 1'b1;
        n = 0;
        while (power_good[g] !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("power_good delay", 8'(e), 8'(n));
        rails_in_regulation[g] = 1'b0;
        repeat (2) @(negedge clk);
        chk("power_good drop", 8'h00, {5'h00, power_good});
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #(8000 * 50);
        fails++;
        summarize();
    end
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        sleep_active = 1'b0;
        out2_feeds_termination = 1'b0;
        pin_enable = '0;
        rails_in_regulation = 3'b000;
        out_bus_controlled = 3'b000;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        foreach (adr[i])
        begin
            rail_host_inst.rd(adr[i], d);
            chk("reset value", 8'h00, d);
        end
        foreach (rows[i])
        begin
            rail_host_inst.wr(8'h9C, rows[i][32:25]);
            rail_host_inst.wr(8'h9F, rows[i][24:17]);
            pin_enable = rows[i][16:10];
            repeat (2) @(negedge clk);
            chk("rail_enable", {1'b0, rows[i][9:3]}, {1'b0, rail_enable});
            chk("conv_pwm", {5'h00, rows[i][2:0]}, {5'h00, conv_pwm});
            rail_host_inst.rd(8'h9C, d);
            chk("mode readback", rows[i][32:25] & 8'h3F, d);
            rail_host_inst.rd(8'h9F, d);
            chk("force-off readback", rows[i][24:17] & 8'hF0, d);
        end
        rail_host_inst.wr(8'h9B, 8'hA5);
        repeat (2) @(negedge clk);
        chk("normal target", 8'h05, {4'h0, ldo_three_target});
        sleep_active = 1'b1;
        @(negedge clk);
        chk("sleep target", 8'h0A, {4'h0, ldo_three_target});
        sleep_active = 1'b0;
        @(negedge clk);
        chk("target restored", 8'h05, {4'h0, ldo_three_target});
        rail_host_inst.wr(8'h9E, 8'h5A);
        rail_host_inst.rd(8'h9E, d);
        chk("unmapped read", 8'h00, d);
        for (int c = 0; c < 8; c++)
        begin
            rail_host_inst.wr(8'h9D, 8'(c << 5));
            good_wait(1, ms[c] * CPM + 1);
        end
        for (int c = 0; c < 4; c++)
        begin
            rail_host_inst.wr(8'h9D, 8'(c));
            good_wait(0, ms[c] * CPM + 1);
        end
        rail_host_inst.wr(8'h9D, 8'h10);
        good_wait(2, ms[4] * CPM + 1);
        rail_host_inst.rd(8'h9D, d);
        chk("delay readback", 8'h10, d);
        out_bus_controlled = 3'b111;
        out2_feeds_termination = 1'b1;
        pin_enable = '0;
        rail_host_inst.wr(8'h9F, 8'h10);
        rail_host_inst.wr(8'h9D, 8'h00);
        rails_in_regulation = 3'b111;
        repeat (4) @(negedge clk);
        chk("bus-controlled good", 8'h02, {5'h00, power_good});
        chk("termination via good", 8'h08, {1'b0, rail_enable});
        rail_host_inst.wr(8'h9F, 8'h00);
        repeat (2) @(negedge clk);
        chk("termination forced off", 8'h00, {1'b0, rail_enable});
        rails_in_regulation = 3'b000;
        out_bus_controlled = 3'b000;
        ce = 1'b0;
        rail_host_inst.wr(8'h9C, 8'h00);
        repeat (2) @(negedge clk);
        chk("frozen pwm", 8'h06, {5'h00, conv_pwm});
        ce = 1'b1;
        rail_host_inst.rd(8'h9C, d);
        chk("write while frozen", 8'h37, d);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk("pwm after reset", 8'h00, {5'h00, conv_pwm});
        chk("rdata after reset", 8'h00, reg_rdata);
        chk("target after reset", 8'h00, {4'h0, ldo_three_target});
        chk("enable after reset", 8'h00, {1'b0, rail_enable});
        chk("good after reset", 8'h00, {5'h00, power_good});
        rail_host_inst.rd(8'h9B, d);
        chk("codes after reset", 8'h00, d);
        summarize();
    end
endmodule // rail_control_register_slice_tb

bind rail_control_register_slice rail_chk #(.CYC_PER_MS(CYC_PER_MS), .CNT_W(CNT_W)) rail_chk_inst (.clk(clk),
    .rstn(rstn), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata), .sleep_active(sleep_active),
    .pin_enable(pin_enable), .rails_in_regulation(rails_in_regulation), .out_bus_controlled(out_bus_controlled),
    .out2_feeds_termination(out2_feeds_termination), .rail_enable(rail_enable), .conv_pwm(conv_pwm),
    .ldo_three_target(ldo_three_target), .power_good(power_good));

// File: testbench/rail_host.sv
`timescale 1ns/1ns
// Released bus fields show the inverse of the last value
module rail_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output rail_ctrl_pkg::reg_req_t reg_req
);
    initial reg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h9F)
            v[3:0] = 4'h0;
        if (a == 8'h9C)
            v[5] = 1'b1;
        @(negedge clk);
        reg_req <= '{a, v, 1'b1, 1'b0};
        @(negedge clk);
        reg_req <= '{~a, ~v, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clk);
        d = reg_rdata;
        reg_req <= '{~a, 8'hFF, 1'b0, 1'b0};
    endtask
endmodule // rail_host
